// ===== rtl/ptc_regs.svh
// Register offsets, field positions, reset values and timings in ns
`ifndef PTC_REGS_SVH
`define PTC_REGS_SVH
`define PTC_OFS_CTRL 8'hb4
`define PTC_OFS_STAT 8'hb8
`define PTC_OFS_ID_HI 8'hbc
`define PTC_OFS_ID_LO 8'hc0
`define PTC_OFS_ADV 8'hc4
`define PTC_OFS_LPA 8'hc8
`define PTC_OFS_EXP 8'hcc
`define PTC_OFS_MODE 8'hd0
`define PTC_OFS_INTST 8'hd4
`define PTC_OFS_INTEN 8'hd8
`define PTC_OFS_FAST 8'hdc
`define PTC_NUM_REGS 11
`define PTC_BIT_SOFT_RESET 15
`define PTC_BIT_LOOPBACK 14
`define PTC_BIT_SPEED 13
`define PTC_BIT_AN_EN 12
`define PTC_BIT_POWER_DOWN 11
`define PTC_BIT_AN_RESTART 9
`define PTC_BIT_DUPLEX 8
`define PTC_BIT_COL_TEST 7
`define PTC_CTRL_RESET 16'h3000
`define PTC_CTRL_WMASK 16'hfb80
`define PTC_STAT_FIXED 16'h7809
`define PTC_ADV_RESET 16'h05e1
`define PTC_ADV_WMASK 16'h25e0
`define PTC_ID_HI_VAL 16'h0123
`define PTC_ID_LO_VAL 16'h4560
`define PTC_SOFT_RESET_NS 1000
`define PTC_AN_RESTART_NS 200
`define PTC_CLK_NS 25
`endif

// ===== rtl/ptc_pkg.sv
// Types for the transceiver control register bank
package ptc_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ptc_apb_req_s;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ptc_apb_rsp_s;
  typedef struct packed {
    logic soft_reset;
    logic loopback;
    logic speed_100;
    logic autoneg_en;
    logic power_down;
    logic autoneg_restart;
    logic full_duplex;
    logic col_test;
  } ptc_ctrl_s;
  typedef enum logic [1:0] {
    PTC_IDLE = 2'b00,
    PTC_BUSY = 2'b01
  } ptc_seq_e;
endpackage

// ===== rtl/ptc_regbank.sv
// Transceiver control and status register bank on APB
// What this block does
// [RQ1] Registers are whole 32-bit words; upper half reads zero.
// [RQ2] Eleven 16-bit registers: seven standard, four vendor.
// [RQ3] Registers decoded at consecutive 4-byte offsets b4h to dch.
// [RQ4] Control bit 15 resets transceiver, self-clears when done, default 0.
// [RQ5] Software clears MAC operating mode when selecting loopback.
// [RQ6] Bit 13 selects 100 or 10 Mb/s, default 1, ignored under autoneg.
// [RQ7] Bit 12 enables auto-negotiation, default 1.
// [RQ8] Bit 11 powers transceiver down, default 0.
// [RQ9] Bit 9 restarts auto-negotiation, self-clears after restart.
// [RQ10] Bit 8 selects full duplex, default 0, ignored under autoneg.
// [RQ11] Bit 7 enables collision test, default 0.
// [RQ12] Status register is read-only; writes change nothing.
// [RQ13] Status bit 15 four-pair ability reads 0.
// [RQ14] Status bits 14 and 13 fast duplex abilities read 1.
// [RQ15] Reserved control bits read zero and ignore writes.
// [RQ16] Self-clearing bits read 1 while their operation is in progress.
//
// Decided for this implementation: the APB register port.
`include "ptc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ptc_regbank #(
  parameter int RESET_CYCLES =
    (`PTC_SOFT_RESET_NS + `PTC_CLK_NS - 1) / `PTC_CLK_NS,
  parameter int RESTART_CYCLES =
    (`PTC_AN_RESTART_NS + `PTC_CLK_NS - 1) / `PTC_CLK_NS
) (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire ptc_pkg::ptc_apb_req_s APB_REQ,
  output ptc_pkg::ptc_apb_rsp_s APB_RSP,
  input wire logic LINK_UP,
  input wire logic AUTONEG_DONE,
  input wire logic [15:0] PARTNER_ABILITY,
  output ptc_pkg::ptc_ctrl_s PHY_CTRL,
  output logic PHY_SPEED_100,
  output logic PHY_FULL_DUPLEX
);
  import ptc_pkg::*;

  localparam int CW = 16;

  logic [15:0] ctrl_r;
  logic [15:0] adv_r;
  logic [15:0] mode_r;
  logic [15:0] inten_r;
  logic [15:0] fast_r;
  logic [CW-1:0] rst_cnt_r;
  logic [CW-1:0] rsa_cnt_r;
  ptc_seq_e rst_st_r;
  ptc_seq_e rsa_st_r;
  logic [2:0] link_sync_r;
  logic [2:0] anc_sync_r;
  logic link_r;
  logic anc_r;
  logic [31:0] rdata_r;
  logic wr_en;
  logic rd_en;
  logic [15:0] wdat;
  logic [15:0] stat_val;
  logic hit;

  // Maps a byte address to a register hit
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a >= `PTC_OFS_CTRL) && (a <= `PTC_OFS_FAST) && // [RQ3]
      (a[1:0] == 2'b00);
  endfunction

  assign hit = reg_hit(APB_REQ.paddr);
  assign wr_en = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
  assign rd_en = APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite;
  assign wdat = APB_REQ.pwdata[15:0]; // [RQ1]

  // Zero-wait answer; unmapped addresses flag an error
  always_comb begin
    APB_RSP.pready = 1'b1;
    APB_RSP.pslverr = APB_REQ.psel && APB_REQ.penable && !hit;
    APB_RSP.prdata = rdata_r;
  end

  // Pin level synchronisers, change taken when stages two and three agree
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      link_sync_r <= 3'h0;
      anc_sync_r <= 3'h0;
      link_r <= 1'b0;
      anc_r <= 1'b0;
    end else begin
      link_sync_r <= {link_sync_r[1:0], LINK_UP};
      anc_sync_r <= {anc_sync_r[1:0], AUTONEG_DONE};
      if (link_sync_r[1] == link_sync_r[2]) begin
        link_r <= link_sync_r[2];
      end
      if (anc_sync_r[1] == anc_sync_r[2]) begin
        anc_r <= anc_sync_r[2];
      end
    end
  end

  // Status value: fixed abilities plus live link and completion
  always_comb begin
    stat_val = `PTC_STAT_FIXED; // [RQ13] [RQ14]
    stat_val[5] = anc_r;
    stat_val[2] = link_r;
  end

  // Control register with self-clearing bits
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ctrl_r <= `PTC_CTRL_RESET; // [RQ6] [RQ7]
    end else begin
      if (wr_en && APB_REQ.paddr == `PTC_OFS_CTRL) begin
        ctrl_r <= (wdat & `PTC_CTRL_WMASK) | // [RQ15]
          (ctrl_r & 16'h0200 &
            {16{rsa_st_r == PTC_BUSY && rsa_cnt_r != '0}}) |
          (ctrl_r & 16'h8000 &
            {16{rst_st_r == PTC_BUSY && rst_cnt_r != '0}}); // [RQ16]
      end else begin
        if (rst_st_r == PTC_BUSY && rst_cnt_r == '0) begin
          ctrl_r <= `PTC_CTRL_RESET; // [RQ4]
        end
        if (rsa_st_r == PTC_BUSY && rsa_cnt_r == '0) begin
          ctrl_r[`PTC_BIT_AN_RESTART] <= 1'b0; // [RQ9]
        end
      end
    end
  end

  // Transceiver reset sequencer
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rst_st_r <= PTC_IDLE;
      rst_cnt_r <= '0;
    end else begin
      case (rst_st_r)
        PTC_IDLE: begin
          if (ctrl_r[`PTC_BIT_SOFT_RESET]) begin
            rst_st_r <= PTC_BUSY; // [RQ4]
            rst_cnt_r <= CW'(RESET_CYCLES - 1);
          end
        end
        PTC_BUSY: begin
          if (rst_cnt_r == '0) begin
            rst_st_r <= PTC_IDLE;
          end else begin
            rst_cnt_r <= rst_cnt_r - 1'b1;
          end
        end
        default: rst_st_r <= PTC_IDLE;
      endcase
    end
  end

  // Auto-negotiation restart sequencer
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rsa_st_r <= PTC_IDLE;
      rsa_cnt_r <= '0;
    end else begin
      case (rsa_st_r)
        PTC_IDLE: begin
          if (ctrl_r[`PTC_BIT_AN_RESTART]) begin
            rsa_st_r <= PTC_BUSY; // [RQ9]
            rsa_cnt_r <= CW'(RESTART_CYCLES - 1);
          end
        end
        PTC_BUSY: begin
          if (rsa_cnt_r == '0) begin
            rsa_st_r <= PTC_IDLE;
          end else begin
            rsa_cnt_r <= rsa_cnt_r - 1'b1;
          end
        end
        default: rsa_st_r <= PTC_IDLE;
      endcase
    end
  end

  // Other writable registers; status and identifiers ignore writes
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      adv_r <= `PTC_ADV_RESET;
      mode_r <= 16'h0000;
      inten_r <= 16'h0000;
      fast_r <= 16'h0000;
    end else if (wr_en) begin
      case (APB_REQ.paddr) // [RQ12]
        `PTC_OFS_ADV: adv_r <= (wdat & `PTC_ADV_WMASK) |
          (`PTC_ADV_RESET & ~`PTC_ADV_WMASK);
        `PTC_OFS_MODE: mode_r <= wdat;
        `PTC_OFS_INTEN: inten_r <= wdat;
        `PTC_OFS_FAST: fast_r <= wdat;
        default: ;
      endcase
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rdata_r <= 32'h0;
    end else if (rd_en) begin
      case (APB_REQ.paddr) // [RQ2] [RQ3]
        `PTC_OFS_CTRL: rdata_r <= {16'h0, ctrl_r}; // [RQ1]
        `PTC_OFS_STAT: rdata_r <= {16'h0, stat_val};
        `PTC_OFS_ID_HI: rdata_r <= {16'h0, 16'(`PTC_ID_HI_VAL)};
        `PTC_OFS_ID_LO: rdata_r <= {16'h0, 16'(`PTC_ID_LO_VAL)};
        `PTC_OFS_ADV: rdata_r <= {16'h0, adv_r};
        `PTC_OFS_LPA: rdata_r <= {16'h0, PARTNER_ABILITY};
        `PTC_OFS_EXP: rdata_r <= 32'h0;
        `PTC_OFS_MODE: rdata_r <= {16'h0, mode_r};
        `PTC_OFS_INTST: rdata_r <= 32'h0;
        `PTC_OFS_INTEN: rdata_r <= {16'h0, inten_r};
        `PTC_OFS_FAST: rdata_r <= {16'h0, fast_r};
        default: rdata_r <= 32'h0;
      endcase
    end
  end

  // Control outputs to the transceiver
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      PHY_CTRL <= '0;
      PHY_SPEED_100 <= 1'b1;
      PHY_FULL_DUPLEX <= 1'b0;
    end else begin
      PHY_CTRL.soft_reset <= (rst_st_r == PTC_BUSY); // [RQ4]
      PHY_CTRL.loopback <= ctrl_r[`PTC_BIT_LOOPBACK]; // [RQ5]
      PHY_CTRL.speed_100 <= ctrl_r[`PTC_BIT_SPEED];
      PHY_CTRL.autoneg_en <= ctrl_r[`PTC_BIT_AN_EN]; // [RQ7]
      PHY_CTRL.power_down <= ctrl_r[`PTC_BIT_POWER_DOWN]; // [RQ8]
      PHY_CTRL.autoneg_restart <= (rsa_st_r == PTC_BUSY); // [RQ9]
      PHY_CTRL.full_duplex <= ctrl_r[`PTC_BIT_DUPLEX];
      PHY_CTRL.col_test <= ctrl_r[`PTC_BIT_COL_TEST]; // [RQ11]
      // Forced values ignored while negotiation runs
      PHY_SPEED_100 <= ctrl_r[`PTC_BIT_AN_EN] ? 1'b1 :
        ctrl_r[`PTC_BIT_SPEED]; // [RQ6]
      PHY_FULL_DUPLEX <= ctrl_r[`PTC_BIT_AN_EN] ? 1'b1 :
        ctrl_r[`PTC_BIT_DUPLEX]; // [RQ10]
    end
  end
endmodule
`default_nettype wire

// ===== bench/ptc_regbank_asserts.sv
// Checker for the transceiver control register bank
`include "ptc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ptc_regbank_asserts #(
  parameter int RESET_CYCLES = 40,
  parameter int RESTART_CYCLES = 8
) (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire ptc_pkg::ptc_apb_req_s APB_REQ,
  input wire ptc_pkg::ptc_apb_rsp_s APB_RSP,
  input wire ptc_pkg::ptc_ctrl_s PHY_CTRL,
  input wire logic PHY_SPEED_100,
  input wire logic PHY_FULL_DUPLEX
);
  import ptc_pkg::*;
  localparam int RST_MAX = RESET_CYCLES + 4;
  localparam int RS_MAX = RESTART_CYCLES + 4;
  logic acc, rd, map, setup_ctl;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  assign acc = APB_REQ.psel && APB_REQ.penable;
  assign rd = acc && !APB_REQ.pwrite;
  assign map = APB_REQ.paddr >= `PTC_OFS_CTRL &&
    APB_REQ.paddr <= `PTC_OFS_FAST && APB_REQ.paddr[1:0] == 2'b00;
  assign setup_ctl = APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite &&
    APB_REQ.paddr == `PTC_OFS_CTRL;
  property p_upper; rd |-> APB_RSP.prdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper)
    else $error("upper half not zero");
  property p_stat;
    rd && APB_REQ.paddr == `PTC_OFS_STAT |-> APB_RSP.prdata[15:13] == 3'b011;
  endproperty
  a_stat: assert property (p_stat)
    else $error("ability bits wrong");
  property p_rsvd; rd && APB_REQ.paddr == `PTC_OFS_CTRL |->
    APB_RSP.prdata[10] == 1'b0 && APB_RSP.prdata[6:0] == 7'h00; endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved control bits set");
  property p_map; acc |-> APB_RSP.pslverr == !map; endproperty
  a_map: assert property (p_map)
    else $error("decode error flag wrong");
  property p_auto; PHY_CTRL.autoneg_en [*2] |->
    PHY_SPEED_100 && PHY_FULL_DUPLEX; endproperty
  a_auto: assert property (p_auto)
    else $error("manual bits used under autoneg");
  property p_manual; (!PHY_CTRL.autoneg_en && $stable(PHY_CTRL)) [*2] |->
    PHY_SPEED_100 == PHY_CTRL.speed_100 &&
    PHY_FULL_DUPLEX == PHY_CTRL.full_duplex; endproperty
  a_manual: assert property (p_manual)
    else $error("manual speed or duplex ignored");
  property p_rst;
    $rose(PHY_CTRL.soft_reset) |-> ##[1:RST_MAX] !PHY_CTRL.soft_reset;
  endproperty
  a_rst: assert property (p_rst)
    else $error("soft reset never clears");
  property p_rdone; $fell(PHY_CTRL.soft_reset) |->
    PHY_CTRL.autoneg_en && PHY_CTRL.speed_100 && !PHY_CTRL.power_down;
  endproperty
  a_rdone: assert property (p_rdone)
    else $error("control not default after reset");
  property p_restart; $rose(PHY_CTRL.autoneg_restart) |->
    ##[1:RS_MAX] !PHY_CTRL.autoneg_restart; endproperty
  a_restart: assert property (p_restart)
    else $error("restart never clears");
  property p_busy; setup_ctl && PHY_CTRL.soft_reset ##1
    PHY_CTRL.soft_reset |-> APB_RSP.prdata[15]; endproperty
  a_busy: assert property (p_busy)
    else $error("busy reset bit reads 0");
  c_rst: cover property ($rose(PHY_CTRL.soft_reset));
  c_restart: cover property ($rose(PHY_CTRL.autoneg_restart));
  c_err: cover property (acc && APB_RSP.pslverr);
endmodule
bind ptc_regbank ptc_regbank_asserts #(
  .RESET_CYCLES(RESET_CYCLES), .RESTART_CYCLES(RESTART_CYCLES)
) u_ptc_regbank_asserts (.CLOCK(CLOCK), .SRST(SRST), .APB_REQ(APB_REQ),
  .APB_RSP(APB_RSP), .PHY_CTRL(PHY_CTRL), .PHY_SPEED_100(PHY_SPEED_100),
  .PHY_FULL_DUPLEX(PHY_FULL_DUPLEX));
`default_nettype wire

// ===== bench/phy_transceiver_control_regs_tb.sv
// Self-checking bench for the transceiver control register bank
`include "ptc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module phy_transceiver_control_regs_tb;
  import ptc_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  ptc_apb_req_s req = '0;
  ptc_apb_rsp_s rsp;
  ptc_ctrl_s ctl;
  logic spd, dpx, e;
  logic [31:0] d;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #12.5 clock = ~clock;
  ptc_regbank #(.RESET_CYCLES(4), .RESTART_CYCLES(4)) u_ptc_regbank (
    .CLOCK(clock), .SRST(srst), .APB_REQ(req), .APB_RSP(rsp),
    .LINK_UP(1'b1), .AUTONEG_DONE(1'b1), .PARTNER_ABILITY(16'ha5a5),
    .PHY_CTRL(ctl), .PHY_SPEED_100(spd), .PHY_FULL_DUPLEX(dpx));
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] wd);
    @(posedge clock);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge clock);
    req.penable <= 1'b1;
    do @(posedge clock); while (rsp.pready !== 1'b1);
    d = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      miscompares++;
      $display("FAIL t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic t_defaults;
    xfer(1'b0, `PTC_OFS_CTRL, 32'h0);
    chk(d, 32'h00003000);
    xfer(1'b0, `PTC_OFS_STAT, 32'h0);
    chk({d[31:13], 13'h0}, 32'h00006000);
    chk({30'h0, spd, dpx}, 32'h3);
    $display("defaults done");
  endtask
  task automatic t_manual;
    xfer(1'b1, `PTC_OFS_CTRL, 32'hffff69ff);
    xfer(1'b0, `PTC_OFS_CTRL, 32'h0);
    chk(d, 32'h00006980);
    chk({27'h0, ctl.loopback, ctl.col_test, ctl.power_down, spd, dpx},
      32'h1f);
    xfer(1'b1, `PTC_OFS_CTRL, 32'h0);
    xfer(1'b0, `PTC_OFS_CTRL, 32'h0);
    chk(d, 32'h0);
    chk({27'h0, ctl.loopback, ctl.col_test, ctl.power_down, spd, dpx},
      32'h0);
    $display("manual done");
  endtask
  task automatic t_selfclr(input logic [31:0] cmd, input logic [31:0] fin);
    int n;
    xfer(1'b1, `PTC_OFS_CTRL, cmd);
    xfer(1'b0, `PTC_OFS_CTRL, 32'h0);
    chk(d & cmd, cmd);
    n = 0;
    while ((d & cmd) != 0 && n < 20) begin
      xfer(1'b0, `PTC_OFS_CTRL, 32'h0);
      n++;
    end
    chk(d, fin);
    $display("self-clear done");
  endtask
  task automatic t_ro_map;
    logic [31:0] s;
    logic [7:0] bad [3] = '{8'hb0, 8'he0, 8'hb6};
    xfer(1'b0, `PTC_OFS_STAT, 32'h0);
    s = d;
    xfer(1'b1, `PTC_OFS_STAT, 32'hffffffff);
    xfer(1'b0, `PTC_OFS_STAT, 32'h0);
    chk(d, s);
    for (int i = 0; i < 11; i++) begin
      xfer(1'b0, 8'(`PTC_OFS_CTRL + 4 * i), 32'h0);
      chk({31'h0, e}, 32'h0);
    end
    xfer(1'b0, `PTC_OFS_LPA, 32'h0);
    chk(d, 32'h0000a5a5);
    foreach (bad[i]) begin
      xfer(1'b0, bad[i], 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(d, 32'h0);
    end
    $display("map done");
  endtask
  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    t_defaults();
    t_manual();
    t_selfclr(32'h8000, 32'h3000);
    t_selfclr(32'h1200, 32'h1000);
    t_ro_map();
    final_report();
  end
endmodule
`default_nettype wire
